// ===== mes_stat_regs.sv
// Pan-zoom vertical settings and per-field motion estimation statistics registers.
`timescale 1ns/100ps
`include "mes_defines.svh"

// Functional notes
// - Host-writable 8-bit vertical start value for pan-zoom candidate vectors.
// - Host-writable 8-bit vertical increment between pan-zoom candidate vectors.
// - Per field, sum squared frame-memory versus new-field differences on new lines.
// - Error sums only count pixels inset 40 pixels and 20 lines from border.
// - Error sum accumulates only in de-interlaced fields, otherwise reads zero.
// - In field doubling mode the error sum reads zero after each field.
// - Per field, sum squared memory-output versus filtered write-back differences.
// - Inconsistency sum only while de-interlacing; zero in field doubling mode.
// - Per field, sum absolute horizontal plus absolute vertical vector components of all blocks.
// - Per field, sum absolute change of each block vector versus previous run.
// - Per field, sum absolute differences to four neighbours from previous run.
// - Count burst errors per field, readable as one byte.
module mes_stat_regs #(
    parameter int BLK_AW = 10
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    // Register access port.
    input  wire logic [7:0]              reg_addr_in,
    input  wire logic                    reg_wr_in,
    input  wire logic [7:0]              reg_wdata_in,
    input  wire logic                    reg_rd_in,
    output logic      [7:0]              reg_rdata_out,
    output logic      [7:0]              pz_y_start_out,
    output logic      [7:0]              pz_y_step_out,
    // Field timing and mode.
    input  wire logic                    field_start_in,
    input  wire logic                    deint_active_in,
    input  wire logic                    field_double_in,
    input  wire logic [9:0]              active_width_in,
    input  wire logic [8:0]              active_lines_in,
    // Pixel stream.
    input  wire logic                    pix_valid_in,
    input  wire logic [9:0]              pix_x_in,
    input  wire logic [8:0]              pix_line_in,
    input  wire logic                    new_line_in,
    input  wire logic [7:0]              prev_frame_pix_in,
    input  wire logic [7:0]              new_field_pix_in,
    input  wire logic [7:0]              writeback_pix_in,
    // Block vector stream.
    input  wire logic                    vec_valid_in,
    input  wire logic [BLK_AW-1:0]       vec_blk_in,
    input  wire mes_pkg::mes_vec_t       vec_x_in,
    input  wire mes_pkg::mes_vec_t       vec_y_in,
    input  wire mes_pkg::mes_vec_t       nb_left_x_in,
    input  wire mes_pkg::mes_vec_t       nb_left_y_in,
    input  wire mes_pkg::mes_vec_t       nb_right_x_in,
    input  wire mes_pkg::mes_vec_t       nb_right_y_in,
    input  wire mes_pkg::mes_vec_t       nb_up_x_in,
    input  wire mes_pkg::mes_vec_t       nb_up_y_in,
    input  wire mes_pkg::mes_vec_t       nb_down_x_in,
    input  wire mes_pkg::mes_vec_t       nb_down_y_in,
    // Burst error events.
    input  wire logic                    burst_err_in
);

    initial begin
        if (BLK_AW < 1 || BLK_AW > 10) begin
            $error("BLK_AW must lie between 1 and 10");
        end
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [8:0] absdiff(input logic [7:0] a, input logic [7:0] b);
        logic signed [8:0] d;
        d = $signed({a[7], a}) - $signed({b[7], b});
        absdiff = d[8] ? 9'(-d) : 9'(d);
    endfunction

    function automatic logic [15:0] sqdiff(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] m;
        m = ({1'b0, a} > {1'b0, b}) ? 9'({1'b0, a} - {1'b0, b}) : 9'({1'b0, b} - {1'b0, a});
        sqdiff = 16'(m * m);
    endfunction

    function automatic logic [15:0] sat16(input logic [31:0] v);
        sat16 = (v[31:16] != 16'h0000) ? 16'hFFFF : v[15:0];
    endfunction

    function automatic logic [7:0] sat8(input logic [19:0] v);
        sat8 = (v[19:8] != 12'h000) ? 8'hFF : v[7:0];
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    mes_pkg::mes_state_s st_reg;
    mes_pkg::mes_state_s st_next;
    logic [15:0]         prev_vec;
    logic                in_window;
    logic [8:0]          tc_term;
    logic [10:0]         sc_term;
    logic [8:0]          act_term;

    // Stage 1 asks the memory for the previous run's vector; stage 2 compares and replaces it.
    mes_vec_mem #(
        .ADDR_W (BLK_AW),
        .DATA_W (16)
    ) u_vec_mem (
        .clk_in      (clk_in),
        .wr_en_in    (st_reg.s1_valid),
        .wr_addr_in  (st_reg.s1_blk[BLK_AW-1:0]),
        .wr_data_in  ({st_reg.s1_vx, st_reg.s1_vy}),
        .rd_addr_in  (vec_blk_in),
        .rd_data_out (prev_vec)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        in_window = (pix_x_in >= `MES_WIN_X_INSET)
                 && ({1'b0, pix_x_in} + {1'b0, `MES_WIN_X_INSET} < {1'b0, active_width_in})
                 && (pix_line_in >= `MES_WIN_Y_INSET)
                 && ({1'b0, pix_line_in} + {1'b0, `MES_WIN_Y_INSET}
                     < {1'b0, active_lines_in});

        act_term = 9'(absdiff(vec_x_in, 8'h00)) + 9'(absdiff(vec_y_in, 8'h00));
        sc_term  = 11'(absdiff(vec_x_in, nb_left_x_in))  + 11'(absdiff(vec_y_in, nb_left_y_in))
                 + 11'(absdiff(vec_x_in, nb_right_x_in)) + 11'(absdiff(vec_y_in, nb_right_y_in))
                 + 11'(absdiff(vec_x_in, nb_up_x_in))    + 11'(absdiff(vec_y_in, nb_up_y_in))
                 + 11'(absdiff(vec_x_in, nb_down_x_in))  + 11'(absdiff(vec_y_in, nb_down_y_in));
        tc_term  = 9'(absdiff(st_reg.s1_vx, prev_vec[15:8])
                 + absdiff(st_reg.s1_vy, prev_vec[7:0]));

        // Host writes; the read-only offsets ignore writes.
        if (reg_wr_in && reg_addr_in == `MES_ADDR_PZ_Y_START) begin
            st_next.pz_y_start = reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == `MES_ADDR_PZ_Y_STEP) begin
            st_next.pz_y_step = reg_wdata_in;
        end

        // Pixel accumulations.
        if (pix_valid_in && new_line_in && in_window && st_reg.deint_fld) begin
            st_next.acc_err = st_reg.acc_err + 32'(sqdiff(prev_frame_pix_in, new_field_pix_in));
            st_next.acc_mti = st_reg.acc_mti + 32'(sqdiff(prev_frame_pix_in, writeback_pix_in));
        end

        // Vector accumulations.
        st_next.s1_valid = vec_valid_in;
        st_next.s1_vx    = vec_x_in;
        st_next.s1_vy    = vec_y_in;
        st_next.s1_blk   = 10'(vec_blk_in);
        if (vec_valid_in) begin
            st_next.acc_act = st_reg.acc_act + 24'(act_term);
            if (st_reg.prev_run_ok) begin
                st_next.acc_sc = (st_reg.acc_sc[19] == 1'b0)
                               ? st_reg.acc_sc + 20'(sc_term) : st_reg.acc_sc;
            end
        end
        if (st_reg.s1_valid && st_reg.prev_run_ok && st_reg.acc_tc[19] == 1'b0) begin
            st_next.acc_tc = st_reg.acc_tc + 20'(tc_term);
        end
        if (burst_err_in && st_reg.acc_burst != 8'hFF) begin
            st_next.acc_burst = st_reg.acc_burst + 8'h01;
        end

        // Field boundary: results of the closing field, fresh accumulators for the next.
        // A burst error or pending temporal term in the boundary cycle itself is counted in the next field;
        // its pixels and the activity and spatial terms of its vector are dropped.
        if (field_start_in) begin
            st_next.res_err   = (st_reg.deint_fld && !st_reg.double_fld)
                              ? sat16(st_reg.acc_err) : 16'h0000;
            st_next.res_mti   = (st_reg.deint_fld && !st_reg.double_fld)
                              ? sat16(st_reg.acc_mti) : 16'h0000;
            st_next.res_act   = sat16({8'h00, st_reg.acc_act});
            st_next.res_tc    = sat8(st_reg.acc_tc);
            st_next.res_sc    = sat8(st_reg.acc_sc);
            st_next.res_burst = st_reg.acc_burst;
            st_next.acc_err   = 32'h0000_0000;
            st_next.acc_mti   = 32'h0000_0000;
            st_next.acc_act   = 24'h00_0000;
            st_next.acc_tc    = (st_reg.s1_valid && st_reg.prev_run_ok) ? 20'(tc_term) : 20'h0_0000;
            st_next.acc_sc    = 20'h0_0000;
            st_next.acc_burst = burst_err_in ? 8'h01 : 8'h00;
            st_next.deint_fld = deint_active_in;
            st_next.double_fld  = field_double_in;
            // One full run must be stored before previous-run comparisons mean anything.
            st_next.prev_run_ok = st_reg.s1_valid | st_reg.prev_run_ok | (st_reg.acc_act != 24'h0)
                                | st_reg.prev_run_ok;
        end

        // Read port: high byte at the lower offset, statistics bytes from the results latched at the last field boundary, other offsets MES_RST_BYTE.
        if (reg_rd_in) begin
            case (reg_addr_in)
                `MES_ADDR_ERR_HI:    st_next.rdata = st_reg.res_err[15:8];
                `MES_ADDR_ERR_LO:    st_next.rdata = st_reg.res_err[7:0];
                `MES_ADDR_MTI_HI:    st_next.rdata = st_reg.res_mti[15:8];
                `MES_ADDR_MTI_LO:    st_next.rdata = st_reg.res_mti[7:0];
                `MES_ADDR_ACT_HI:    st_next.rdata = st_reg.res_act[15:8];
                `MES_ADDR_ACT_LO:    st_next.rdata = st_reg.res_act[7:0];
                `MES_ADDR_TEMP_CONS: st_next.rdata = st_reg.res_tc;
                `MES_ADDR_SPAT_CONS: st_next.rdata = st_reg.res_sc;
                `MES_ADDR_BURST_CNT: st_next.rdata = st_reg.res_burst;
                default:             st_next.rdata = `MES_RST_BYTE;
            endcase
        end

        if (rst_in) begin
            st_next = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign reg_rdata_out  = st_reg.rdata;
    assign pz_y_start_out = st_reg.pz_y_start;
    assign pz_y_step_out  = st_reg.pz_y_step;

endmodule

// ===== mes_defines.svh
// Register offsets, field windows and widths for the motion statistics register bank.
`ifndef MES_DEFINES_SVH
`define MES_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define MES_ADDR_PZ_Y_START  8'h9E
`define MES_ADDR_PZ_Y_STEP   8'h9F
`define MES_ADDR_ERR_HI      8'hA0
`define MES_ADDR_ERR_LO      8'hA1
`define MES_ADDR_MTI_HI      8'hA2
`define MES_ADDR_MTI_LO      8'hA3
`define MES_ADDR_ACT_HI      8'hA4
`define MES_ADDR_ACT_LO      8'hA5
`define MES_ADDR_TEMP_CONS   8'hA6
`define MES_ADDR_SPAT_CONS   8'hA7
`define MES_ADDR_BURST_CNT   8'hA8

// ----------------------------------------------------------------------------
// Reset values and measurement window
// ----------------------------------------------------------------------------
`define MES_RST_BYTE         8'h00
`define MES_WIN_X_INSET      10'h028
`define MES_WIN_Y_INSET      9'h014
`define MES_VEC_DEPTH        1024

`endif

// ===== mes_pkg.sv
// Types shared by the motion statistics register bank and its vector memory.
package mes_pkg;

    typedef logic signed [7:0] mes_vec_t;

    typedef struct packed {
        logic [7:0]  pz_y_start;
        logic [7:0]  pz_y_step;
        logic [31:0] acc_err;
        logic [31:0] acc_mti;
        logic [23:0] acc_act;
        logic [19:0] acc_tc;
        logic [19:0] acc_sc;
        logic [7:0]  acc_burst;
        logic [15:0] res_err;
        logic [15:0] res_mti;
        logic [15:0] res_act;
        logic [7:0]  res_tc;
        logic [7:0]  res_sc;
        logic [7:0]  res_burst;
        logic        deint_fld;
        logic        double_fld;
        logic        prev_run_ok;
        logic        s1_valid;
        logic [7:0]  s1_vx;
        logic [7:0]  s1_vy;
        logic [9:0]  s1_blk;
        logic [7:0]  rdata;
    } mes_state_s;

    typedef struct packed {
        logic [15:0] rdata;
    } mes_mem_state_s;

endpackage

// ===== mes_vec_mem.sv
// Previous-run block vector store with registered read data.
`timescale 1ns/100ps

module mes_vec_mem #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 16
) (
    input  wire logic              clk_in,
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic      [DATA_W-1:0] rd_data_out
);

    initial begin
        if (DATA_W != 16) begin
            $error("mes_vec_mem holds one 16-bit vector pair per entry");
        end
    end

    logic           [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    mes_pkg::mes_mem_state_s     st_reg;
    mes_pkg::mes_mem_state_s     st_next;

    // Contents need no reset: the owner ignores them until one full run is stored.
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_comb begin
        st_next       = st_reg;
        st_next.rdata = mem[rd_addr_in];
    end

    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end

    assign rd_data_out = st_reg.rdata;

endmodule

// ===== mes_stat_regs_asserts.sv
// Concurrent checks on the ports of the motion statistics register bank.
`timescale 1ns/100ps
`include "mes_defines.svh"
module mes_stat_regs_chk (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [7:0] pz_y_start_out,
    input wire logic [7:0] pz_y_step_out,
    input wire logic       field_start_in,
    input wire logic       deint_active_in,
    input wire logic       field_double_in,
    input wire logic       burst_err_in
);
    // --------------------------------------------------------------------
    // Field tracking
    // --------------------------------------------------------------------
    // A field that starts without de-interlacing, or in doubling mode, must close with zeros.
    logic       cur_ok;
    logic       res_zero;
    logic [7:0] bcnt;
    logic [7:0] blat;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cur_ok   <= 1'b0;
            res_zero <= 1'b1;
            bcnt     <= 8'h00;
            blat     <= 8'h00;
        end else if (field_start_in) begin
            cur_ok   <= deint_active_in && !field_double_in;
            res_zero <= !cur_ok;
            blat     <= bcnt;
            bcnt     <= {7'h00, burst_err_in};
        end else if (burst_err_in && bcnt != 8'hFF) begin
            bcnt <= bcnt + 8'h01;
        end
    end
    // --------------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_WR_START: assert property (
        reg_wr_in && reg_addr_in == `MES_ADDR_PZ_Y_START |=> pz_y_start_out == $past(reg_wdata_in))
        else $error("Start value missed a write.");
    AST_WR_STEP: assert property (
        reg_wr_in && reg_addr_in == `MES_ADDR_PZ_Y_STEP |=> pz_y_step_out == $past(reg_wdata_in))
        else $error("Step value missed a write.");
    AST_START_HOLD: assert property (
        !(reg_wr_in && reg_addr_in == `MES_ADDR_PZ_Y_START) |=> $stable(pz_y_start_out))
        else $error("Start value changed without a write.");
    AST_WO_READ_ZERO: assert property (
        reg_rd_in && reg_addr_in inside {`MES_ADDR_PZ_Y_START, `MES_ADDR_PZ_Y_STEP}
        |=> reg_rdata_out == 8'h00) else $error("Write-only register read back nonzero.");
    AST_RD_HOLD: assert property (
        !reg_rd_in |=> $stable(reg_rdata_out)) else $error("Read data moved without a read.");
    AST_ERR_ZERO: assert property (
        reg_rd_in && res_zero && reg_addr_in inside {`MES_ADDR_ERR_HI, `MES_ADDR_ERR_LO}
        |=> reg_rdata_out == 8'h00) else $error("Error sum nonzero for an idle field.");
    AST_MTI_ZERO: assert property (
        reg_rd_in && res_zero && reg_addr_in inside {`MES_ADDR_MTI_HI, `MES_ADDR_MTI_LO}
        |=> reg_rdata_out == 8'h00) else $error("Inconsistency sum nonzero for an idle field.");
    AST_BURST_LATCH: assert property (
        reg_rd_in && reg_addr_in == `MES_ADDR_BURST_CNT |=> reg_rdata_out == $past(blat))
        else $error("Burst count differs from the closed field.");
    COV_DEINT: cover property (field_start_in && deint_active_in && !field_double_in);
    COV_DOUBLE: cover property (field_start_in && field_double_in);
    COV_BURST: cover property (reg_rd_in && reg_addr_in == `MES_ADDR_BURST_CNT && blat != 8'h00);
endmodule
bind mes_stat_regs mes_stat_regs_chk i_mes_stat_regs_chk (.clk_in, .rst_in, .reg_addr_in,
    .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .pz_y_start_out, .pz_y_step_out,
    .field_start_in, .deint_active_in, .field_double_in, .burst_err_in);

// ===== mes_host_model.sv
// Host controller model issuing single register writes and reads.
`timescale 1ns/100ps
module mes_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] reg_rdata_in,
    output logic      [7:0] reg_addr_out,
    output logic            reg_wr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            reg_rd_out
);
    initial begin
        {reg_addr_out, reg_wr_out, reg_wdata_out, reg_rd_out} = '0;
    end
    // Released lines show the inverse of the last value, so stale data is never mistaken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out  <= a;
        reg_wdata_out <= d;
        reg_wr_out    <= 1'b1;
        @(posedge clk_in);
        reg_addr_out  <= ~a;
        reg_wdata_out <= ~d;
        reg_wr_out    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_rd_out   <= 1'b1;
        @(posedge clk_in);
        reg_addr_out <= ~a;
        reg_rd_out   <= 1'b0;
        #1;
        d = reg_rdata_in;
    endtask
endmodule

// ===== tb_mes_stat_regs.sv
// Testbench for the motion statistics register bank.
`timescale 1ns/100ps
`include "mes_defines.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb_mes_stat_regs;
    logic              clk_in, rst_in, reg_wr_in, reg_rd_in, field_start_in, deint_active_in;
    logic              field_double_in, pix_valid_in, new_line_in, vec_valid_in, burst_err_in;
    logic [7:0]        reg_addr_in, reg_wdata_in, reg_rdata_out, pz_y_start_out, pz_y_step_out;
    logic [7:0]        prev_frame_pix_in, new_field_pix_in, writeback_pix_in, d;
    logic [9:0]        active_width_in, pix_x_in;
    logic [8:0]        active_lines_in, pix_line_in;
    logic [3:0]        vec_blk_in;
    mes_pkg::mes_vec_t vec_x_in, vec_y_in, nb_left_x_in, nb_left_y_in, nb_right_x_in;
    mes_pkg::mes_vec_t nb_right_y_in, nb_up_x_in, nb_up_y_in, nb_down_x_in, nb_down_y_in;
    int                error_cnt, total_checks;
    mes_stat_regs #(.BLK_AW(4)) i_mes_stat_regs (
        .clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rdata_out,
        .pz_y_start_out, .pz_y_step_out, .field_start_in, .deint_active_in, .field_double_in,
        .active_width_in, .active_lines_in, .pix_valid_in, .pix_x_in, .pix_line_in, .new_line_in,
        .prev_frame_pix_in, .new_field_pix_in, .writeback_pix_in, .vec_valid_in, .vec_blk_in,
        .vec_x_in, .vec_y_in, .nb_left_x_in, .nb_left_y_in, .nb_right_x_in, .nb_right_y_in,
        .nb_up_x_in, .nb_up_y_in, .nb_down_x_in, .nb_down_y_in, .burst_err_in);
    mes_host_model i_mes_host_model (.clk_in, .reg_rdata_in(reg_rdata_out),
        .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in), .reg_wdata_out(reg_wdata_in),
        .reg_rd_out(reg_rd_in));
    // --------------------------------------------------------------------
    // Stimulus tasks
    // --------------------------------------------------------------------
    task automatic st(input logic pv, input logic vv, input logic be);
        @(posedge clk_in);
        pix_valid_in <= pv;
        vec_valid_in <= vv;
        burst_err_in <= be;
    endtask
    task automatic px(input int x, input int l, input logic nl, input int p, input int n,
                      input int w);
        st(1'b1, 1'b0, 1'b0);
        pix_x_in          <= 10'(x);
        pix_line_in       <= 9'(l);
        new_line_in       <= nl;
        prev_frame_pix_in <= 8'(p);
        new_field_pix_in  <= 8'(n);
        writeback_pix_in  <= 8'(w);
    endtask
    task automatic vt(input int b, input int x, input int y, input int n);
        st(1'b0, 1'b1, 1'b0);
        vec_blk_in <= 4'(b);
        vec_x_in   <= 8'(x);
        vec_y_in   <= 8'(y);
        {nb_left_x_in, nb_right_x_in, nb_up_x_in, nb_down_x_in} <= {4{8'(n)}};
        {nb_left_y_in, nb_right_y_in, nb_up_y_in, nb_down_y_in} <= {4{8'(-n)}};
    endtask
    task automatic fs(input logic de, input logic db);
        st(1'b0, 1'b0, 1'b0);
        field_start_in  <= 1'b1;
        deint_active_in <= de;
        field_double_in <= db;
        @(posedge clk_in);
        field_start_in <= 1'b0;
    endtask
    // Window edges at width 100 and 50 lines: only the first two pixels and the last, which is not on a new line, fall inside.
    task automatic fld(input int s);
        px(40, 20, 1'b1, 10, 7, 4);
        px(59, 29, 1'b1, 20, 15, 18);
        px(39, 20, 1'b1, 99, 0, 0);
        px(60, 25, 1'b1, 99, 0, 0);
        px(50, 19, 1'b1, 99, 0, 0);
        px(50, 30, 1'b1, 99, 0, 0);
        px(50, 25, 1'b0, 99, 0, 0);
        vt(1, 3 + s, -2, s);
        vt(2, -4, 1, s);
        repeat (3 - 2 * s) begin
            st(1'b0, 1'b0, 1'b1);
            st(1'b0, 1'b0, 1'b0);
        end
        repeat (4) st(1'b0, 1'b0, 1'b0);
    endtask
    // Expected bytes are packed in address order from the high error byte onwards.
    task automatic chk(input logic [71:0] e);
        for (int i = 0; i < 9; i++) begin
            i_mes_host_model.rd(8'(`MES_ADDR_ERR_HI + i), d);
            `CHK($sformatf("reg %h", `MES_ADDR_ERR_HI + i), e[71 - 8 * i -: 8], d)
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // --------------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        rst_in = 1'b1;
        {pix_valid_in, new_line_in, vec_valid_in, burst_err_in} = '0;
        {field_start_in, deint_active_in, field_double_in, error_cnt, total_checks} = '0;
        {pix_x_in, pix_line_in, prev_frame_pix_in, new_field_pix_in, writeback_pix_in} = '0;
        {vec_blk_in, vec_x_in, vec_y_in, nb_left_x_in, nb_left_y_in, nb_right_x_in} = '0;
        {nb_right_y_in, nb_up_x_in, nb_up_y_in, nb_down_x_in, nb_down_y_in} = '0;
        active_width_in = 10'h064;
        active_lines_in = 9'h032;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        i_mes_host_model.wr(`MES_ADDR_ERR_HI, 8'hFF);
        chk('0);
        i_mes_host_model.wr(`MES_ADDR_PZ_Y_START, 8'hA5);
        i_mes_host_model.wr(`MES_ADDR_PZ_Y_STEP, 8'h3C);
        `CHK("y start", 8'hA5, pz_y_start_out)
        `CHK("y step", 8'h3C, pz_y_step_out)
        i_mes_host_model.rd(`MES_ADDR_PZ_Y_START, d);
        `CHK("y start read", 8'h00, d)
        fs(1'b1, 1'b0);
        fld(0);
        fs(1'b0, 1'b0);
        chk({16'h0022, 16'h0028, 16'h000A, 8'h00, 8'h00, 8'h03});
        fld(1);
        fs(1'b1, 1'b1);
        chk({32'h0, 16'h000B, 8'h01, 8'h2C, 8'h01});
        fld(1);
        fs(1'b1, 1'b0);
        chk({32'h0, 16'h000B, 8'h00, 8'h2C, 8'h01});
        conclude();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge clk_in);
        error_cnt++;
        conclude();
    end
endmodule
